// file: hw/cdg_defs.svh
// constants for the commutation direction guard
`ifndef CDG_DEFS_SVH
`define CDG_DEFS_SVH

// --------------------------------------------------
// timing
// --------------------------------------------------
// oscillator period in ns as nominally set
`define CDG_OSC_PERIOD_NS 20000
`define CDG_CLK_PERIOD_NS 10
`define CDG_OSC_CYCLES (`CDG_OSC_PERIOD_NS / `CDG_CLK_PERIOD_NS)
// speed pulse width in clock cycles
`define CDG_PULSE_CYCLES 4
// direction shift register depth
`define CDG_SHIFT_DEPTH 2

// --------------------------------------------------
// reset values
// --------------------------------------------------
`define CDG_DIR_RESET 1'b0
`define CDG_DRIVE_OFF 3'h0

`endif

// file: hw/cdg_pkg.sv
// types of the commutation direction guard
package cdg_pkg;

    typedef struct packed {
        logic [2:0] high_side_drive;
        logic [2:0] low_side_drive;
    } cdg_drive_t;

endpackage : cdg_pkg

// file: hw/cdg_top.sv
// commutation direction guard: sensor decode, direction latch and pwm chop
`timescale 1ns/1ns
`include "cdg_defs.svh"

module cdg_top #(
    parameter int OSC_CYCLES = `CDG_OSC_CYCLES,
    parameter int PULSE_CYCLES = `CDG_PULSE_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_rotor_sensor_lines,
    input wire logic i_dir,
    input wire logic i_speed_above,
    input wire logic i_pwm_trip,
    output logic [2:0] o_high_side_drive,
    output logic [2:0] o_low_side_drive,
    output logic o_speed_pulse,
    output logic o_osc_tick
);

    // the oscillator counter is 16 bits wide and the pulse counter 8 bits
    if (OSC_CYCLES < 2 || OSC_CYCLES > 65535)
    begin : g_bad_osc
        $error("cdg_top: OSC_CYCLES out of range");
    end
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255)
    begin : g_bad_pulse
        $error("cdg_top: PULSE_CYCLES out of range");
    end

    // --------------------------------------------------
    // commutation table
    // --------------------------------------------------
    // codes 000 and 111 cannot come from 120 degree sensors, so they blank
    function automatic cdg_pkg::cdg_drive_t decode_phase(input logic [2:0] code,
                                                        input logic fwd);
        cdg_pkg::cdg_drive_t d;
        logic [2:0] hs;
        logic [2:0] ls;
        hs = `CDG_DRIVE_OFF;
        ls = `CDG_DRIVE_OFF;
        unique case (code)
            3'h1:
            begin
                hs = 3'h1;
                ls = 3'h2;
            end
            3'h3:
            begin
                hs = 3'h1;
                ls = 3'h4;
            end
            3'h2:
            begin
                hs = 3'h2;
                ls = 3'h4;
            end
            3'h6:
            begin
                hs = 3'h2;
                ls = 3'h1;
            end
            3'h4:
            begin
                hs = 3'h4;
                ls = 3'h1;
            end
            3'h5:
            begin
                hs = 3'h4;
                ls = 3'h2;
            end
            default:
            begin
                hs = `CDG_DRIVE_OFF;
                ls = `CDG_DRIVE_OFF;
            end
        endcase
        // reverse rotation swaps the upper and lower switch of each phase
        d.high_side_drive = fwd ? hs : ls;
        d.low_side_drive = fwd ? ls : hs;
        return d;
    endfunction : decode_phase

    // --------------------------------------------------
    // pwm oscillator
    // --------------------------------------------------
    logic [15:0] osc_count;
    logic [15:0] next_osc_count;
    logic osc_tick;

    // the tick marks the last count of a period, so a period is OSC_CYCLES long
    assign osc_tick = (osc_count == 16'(OSC_CYCLES - 1));

    always_comb
    begin
        if (osc_tick)
            next_osc_count = 16'h0000;
        else
            next_osc_count = osc_count + 16'h0001;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            osc_count <= 16'h0000;
        else
            osc_count <= next_osc_count;
    end

    // the observed tick trails the internal one by a clock, as all outputs are registered

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_osc_tick <= 1'b0;
        else
            o_osc_tick <= osc_tick;
    end

    // --------------------------------------------------
    // direction latch
    // --------------------------------------------------
    // the latch is modelled as a register updated every clock while open;
    // one clock of lag is far below one oscillator period
    logic dir_latch;
    logic next_dir_latch;

    // a fast motor keeps its sense: reversing it would dump stored energy
    always_comb
    begin
        if (i_speed_above)
            next_dir_latch = dir_latch;
        else
            next_dir_latch = i_dir;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            dir_latch <= `CDG_DIR_RESET;
        else
            dir_latch <= next_dir_latch;
    end

    // --------------------------------------------------
    // direction shift register
    // --------------------------------------------------
    logic [`CDG_SHIFT_DEPTH-1:0] dir_shift;
    logic [`CDG_SHIFT_DEPTH-1:0] next_dir_shift;

    // stage 0 takes the latch and each later stage its neighbour, all on one tick;
    // nothing moves between ticks, so a turn can never be instant
    assign next_dir_shift[0] = osc_tick ? dir_latch : dir_shift[0];

    for (genvar s = 1; s < `CDG_SHIFT_DEPTH; s++)
    begin : g_dir_stage
        assign next_dir_shift[s] = osc_tick ? dir_shift[s-1] : dir_shift[s];
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            dir_shift <= {`CDG_SHIFT_DEPTH{`CDG_DIR_RESET}};
        else
            dir_shift <= next_dir_shift;
    end

    logic latch_busy;
    logic shift_busy;
    logic blank;

    // a turn is in flight while the latch differs from i_dir or the last stage from the latch; the
    // motor coasts meanwhile, which is the whole point of the guard
    assign latch_busy = (i_dir != dir_latch);
    assign shift_busy = (dir_latch != dir_shift[`CDG_SHIFT_DEPTH-1]);
    assign blank = latch_busy || shift_busy;

    // --------------------------------------------------
    // pwm latch
    // --------------------------------------------------
    logic pwm_on;
    logic next_pwm_on;

    // a trip in the tick cycle keeps the latch clear: the comparator has the
    // last word, so an over-limit phase is not switched on again
    always_comb
    begin
        if (i_pwm_trip)
            next_pwm_on = 1'b0;
        else if (osc_tick)
            next_pwm_on = 1'b1;
        else
            next_pwm_on = pwm_on;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pwm_on <= 1'b0;
        else
            pwm_on <= next_pwm_on;
    end

    // --------------------------------------------------
    // drive outputs
    // --------------------------------------------------
    cdg_pkg::cdg_drive_t next_drive;

    always_comb
    begin
        next_drive = decode_phase(i_rotor_sensor_lines, dir_shift[`CDG_SHIFT_DEPTH-1]);
        if (blank)
        begin
            next_drive.high_side_drive = `CDG_DRIVE_OFF;
            next_drive.low_side_drive = `CDG_DRIVE_OFF;
        end
        else if (!pwm_on || i_pwm_trip)
        begin
            // only the high side chops; the low side keeps the return path
            next_drive.high_side_drive = `CDG_DRIVE_OFF;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_high_side_drive <= `CDG_DRIVE_OFF;
            o_low_side_drive <= `CDG_DRIVE_OFF;
        end
        else
        begin
            o_high_side_drive <= next_drive.high_side_drive;
            o_low_side_drive <= next_drive.low_side_drive;
        end
    end

    // --------------------------------------------------
    // speed pulse on direction toggle
    // --------------------------------------------------
    logic dir_prev;
    logic dir_primed;
    logic dir_toggle;
    logic [7:0] pulse_count;
    logic [7:0] next_pulse_count;

    // dir_prev holds a real sample only one clock after reset, so a pin that
    // idles high does not fake a toggle at release
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            dir_prev <= `CDG_DIR_RESET;
            dir_primed <= 1'b0;
        end
        else
        begin
            dir_prev <= i_dir;
            dir_primed <= 1'b1;
        end
    end

    assign dir_toggle = dir_primed && (i_dir != dir_prev);

    // a further toggle restarts the pulse rather than queueing a second one
    always_comb
    begin
        if (dir_toggle)
            next_pulse_count = 8'(PULSE_CYCLES);
        else if (pulse_count != 8'h00)
            next_pulse_count = pulse_count - 8'h01;
        else
            next_pulse_count = pulse_count;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pulse_count <= 8'h00;
        else
            pulse_count <= next_pulse_count;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_speed_pulse <= 1'b0;
        else
            o_speed_pulse <= dir_toggle || (pulse_count > 8'h01);
    end

endmodule : cdg_top

// file: tb/cdg_props.sv
// port assertions for the commutation direction guard
`timescale 1ns/1ns
module cdg_props #(parameter int OSC_CYCLES = 8, parameter int PULSE_CYCLES = 4) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_rotor_sensor_lines,
    input wire logic i_dir,
    input wire logic i_speed_above,
    input wire logic i_pwm_trip,
    input wire logic [2:0] o_high_side_drive,
    input wire logic [2:0] o_low_side_drive,
    input wire logic o_speed_pulse,
    input wire logic o_osc_tick
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    // the repetition counts below are written for these values only
    if (OSC_CYCLES != 8 || PULSE_CYCLES != 4)
    begin : g_bad_cfg
        $error("cdg_props: counts written for OSC_CYCLES 8 and PULSE_CYCLES 4");
    end
    wire logic off = !(|{o_high_side_drive, o_low_side_drive});
    turn_blank_a: assert property ($changed(i_dir) ##1 $stable(i_dir) |=> off)
        else $error("drive during turn");
    turn_slow_a: assert property (!i_speed_above && $changed(i_dir) ##1 $stable(i_dir)
        |=> off[*7]) else $error("turn too fast");
    dir_hold_a: assert property (i_speed_above && $changed(i_dir)
        ##1 (i_speed_above && $stable(i_dir))[*8] |=> off) else $error("latch moved");
    pulse_len_a: assert property ($changed(i_dir) |=> o_speed_pulse[*4])
        else $error("short speed pulse");
    tick_gap_a: assert property (o_osc_tick |=> !o_osc_tick[*7] ##1 o_osc_tick)
        else $error("tick spacing");
    trip_chop_a: assert property (i_pwm_trip |=> o_high_side_drive == 3'h0)
        else $error("no chop");
    bad_code_a: assert property (i_rotor_sensor_lines inside {3'h0, 3'h7} |=> off)
        else $error("drive on bad code");
    one_pair_a: assert property ($onehot0(o_high_side_drive) && $onehot0(o_low_side_drive)
        && !(|(o_high_side_drive & o_low_side_drive))) else $error("pair clash");
    cover property (!i_speed_above && $changed(i_dir));
    cover property (i_speed_above && $changed(i_dir));
    cover property (i_pwm_trip);
    cover property (i_rotor_sensor_lines inside {3'h0, 3'h7});
endmodule : cdg_props

// file: tb/cdg_rotor.sv
// rotor sensor model: six-state walk, equal-level codes on demand
`timescale 1ns/1ns
module cdg_rotor (
    input wire logic i_sys_clk,
    input wire logic i_step,
    input wire logic i_bad,
    output logic [2:0] o_rotor_sensor_lines
);
    localparam logic [2:0] SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    logic [2:0] pos = 3'h0;
    always @(posedge i_sys_clk)
        if (i_step)
            pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
    // one line changes per step, except when a faulty sensor is asked for
    assign o_rotor_sensor_lines = i_bad ? {3{pos[0]}} : SEQ[pos];
endmodule : cdg_rotor

// file: tb/cdg_top_tb_top.sv
// self-checking bench for the commutation direction guard
`timescale 1ns/1ns
module cdg_top_tb_top;
    logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_dir = 1'b0, bad = 1'b0;
    logic i_speed_above = 1'b0, i_pwm_trip = 1'b0, step = 1'b0;
    logic [2:0] i_rotor_sensor_lines;
    logic o_speed_pulse, o_osc_tick;
    cdg_pkg::cdg_drive_t drv;
    int n_fail = 0, total_checks = 0;
    localparam logic [5:0] FWD [8] = '{6'h00, 6'h0A, 6'h14, 6'h0C, 6'h21, 6'h22, 6'h11, 6'h00};
    always #5 i_sys_clk = ~i_sys_clk;
    cdg_rotor cdg_rotor_i (.i_sys_clk, .i_step(step), .i_bad(bad),
        .o_rotor_sensor_lines(i_rotor_sensor_lines));
    cdg_top #(.OSC_CYCLES(8)) cdg_top_i (.i_sys_clk, .i_rst_n, .i_rotor_sensor_lines,
        .i_dir, .i_speed_above, .i_pwm_trip, .o_speed_pulse, .o_osc_tick,
        .o_high_side_drive(drv.high_side_drive), .o_low_side_drive(drv.low_side_drive));
    task automatic cyc(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask : cyc
    task automatic check(input logic [5:0] seen, input logic [5:0] exp);
        total_checks++;
        n_fail += (seen !== exp);
        if (seen !== exp) $display("[ERR] %0t got %h exp %h", $time, seen, exp);
    endtask : check
    // reverse sense swaps the high and low halves
    function automatic logic [5:0] want(input logic fwd);
        logic [5:0] r = FWD[i_rotor_sensor_lines];
        return fwd ? r : {r[2:0], r[5:3]};
    endfunction : want
    task automatic walk(input logic fwd);
        step = 1'b1;
        cyc(1);
        step = 1'b0;
        cyc(2);
        check(drv, bad ? 6'h00 : want(fwd));
    endtask : walk
    task automatic t_decode(input logic fwd);
        repeat (6) walk(fwd);
    endtask : t_decode
    task automatic t_bad();
        bad = 1'b1;
        repeat (2) walk(1'b0);
        bad = 1'b0;
    endtask : t_bad
    task automatic t_turn();
        i_dir = 1'b1;
        cyc(1);
        check({5'h00, o_speed_pulse}, 6'h01);
        cyc(2);
        check(drv, 6'h00);
        cyc(6);
        check(drv, 6'h00);
        check({5'h00, o_speed_pulse}, 6'h00);
        cyc(13);
        check(drv, want(1'b1));
    endtask : t_turn
    task automatic t_chop();
        while (o_osc_tick !== 1'b1) cyc(1);
        i_pwm_trip = 1'b1;
        cyc(1);
        i_pwm_trip = 1'b0;
        cyc(1);
        check(drv, want(1'b1) & 6'h07);
        cyc(8);
        check(drv, want(1'b1));
    endtask : t_chop
    task automatic t_hold();
        i_speed_above = 1'b1;
        i_dir = 1'b0;
        cyc(1);
        check({5'h00, o_speed_pulse}, 6'h01);
        cyc(29);
        check(drv, 6'h00);
        i_speed_above = 1'b0;
        cyc(22);
        check(drv, want(1'b0));
    endtask : t_hold
    // reset in mid-run with the pin already reversed: no false pulse, a full turn
    task automatic t_reset();
        i_rst_n = 1'b0;
        i_dir = 1'b1;
        cyc(2);
        i_rst_n = 1'b1;
        cyc(2);
        check({5'h00, o_speed_pulse}, 6'h00);
        check(drv, 6'h00);
        cyc(12);
        check(drv, 6'h00);
        cyc(8);
        check(drv, want(1'b1));
    endtask : t_reset
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    initial
    begin
        cyc(20);
        i_rst_n = 1'b1;
        cyc(12);
        t_decode(1'b0);
        t_bad();
        t_turn();
        t_decode(1'b1);
        t_chop();
        t_hold();
        t_reset();
        conclude();
    end
    initial
    begin
        repeat (2000) @(posedge i_sys_clk);
        n_fail++;
        conclude();
    end
endmodule : cdg_top_tb_top
bind cdg_top cdg_props #(.OSC_CYCLES(OSC_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) cdg_props_i (
    .i_sys_clk, .i_rst_n, .i_rotor_sensor_lines, .i_dir, .i_speed_above, .i_pwm_trip,
    .o_high_side_drive, .o_low_side_drive, .o_speed_pulse, .o_osc_tick);
